// File: shared/mcr_pkg.sv
/*
 * Shared constants of the motor configuration register bank: register
 * addresses, field positions and widths, reset values and timing counts.
 * Assumes a 100 MHz system clock and an 8-bit register address space.
 */
package mcr_pkg;

    // =========================================================================
    // Clock and timing
    // =========================================================================
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned TACH_DELAY_MS      = 280;
    localparam int unsigned NS_PER_MS          = 1000000;
    localparam int unsigned TACH_DELAY_CYCLES  = (TACH_DELAY_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DELAY_CNT_W        = 32;

    // =========================================================================
    // Register addresses and reset values
    // =========================================================================
    localparam int unsigned ADDR_W             = 8;
    localparam int unsigned DATA_W             = 16;
    localparam logic [7:0]  ADDR_CONFIG_A      = 8'h90;
    localparam logic [7:0]  ADDR_CONFIG_B      = 8'h91;
    localparam logic [15:0] RESET_CONFIG_A     = 16'h0000;
    localparam logic [15:0] RESET_CONFIG_B     = 16'h0000;
    localparam logic [15:0] WMASK_CONFIG_B     = 16'h7fff;

    // =========================================================================
    // Field positions, first register
    // =========================================================================
    localparam int unsigned DITHER_MSB         = 15;
    localparam int unsigned DITHER_LSB         = 14;
    localparam int unsigned TACH_OL_MSB        = 13;
    localparam int unsigned TACH_OL_LSB        = 12;
    localparam int unsigned TACH_DIV_MSB       = 11;
    localparam int unsigned TACH_DIV_LSB       = 8;
    localparam int unsigned CYCLE_ADJ_BIT      = 7;
    localparam int unsigned RES_EXP_MSB        = 6;
    localparam int unsigned RES_EXP_LSB        = 4;
    localparam int unsigned RES_MAN_MSB        = 3;
    localparam int unsigned RES_MAN_LSB        = 0;

    // =========================================================================
    // Field positions, second register
    // =========================================================================
    localparam int unsigned RSVD_B_BIT         = 15;
    localparam int unsigned BACK_EMF_EXP_MSB       = 14;
    localparam int unsigned BACK_EMF_EXP_LSB       = 12;
    localparam int unsigned BACK_EMF_MAN_MSB       = 11;
    localparam int unsigned BACK_EMF_MAN_LSB       = 8;
    localparam int unsigned ADV_MODE_BIT       = 7;
    localparam int unsigned ADV_EXP_MSB        = 6;
    localparam int unsigned ADV_EXP_LSB        = 4;
    localparam int unsigned ADV_MAN_MSB        = 3;
    localparam int unsigned ADV_MAN_LSB        = 0;

    // =========================================================================
    // Encodings and derived widths
    // =========================================================================
    localparam int unsigned MAN_W              = 4;
    localparam int unsigned EXP_W              = 3;
    localparam int unsigned SCALED_W           = 11;
    localparam int unsigned LEVEL_W            = 12;
    localparam logic [1:0]  TACH_OL_BOTH       = 2'h0;
    localparam logic [1:0]  TACH_OL_DELAYED    = 2'h1;
    localparam logic [1:0]  TACH_OL_FIRST      = 2'h2;
    localparam logic [4:0]  DITHER_PCT_OFF     = 5'h00;
    localparam logic [4:0]  DITHER_PCT_LOW     = 5'h05;
    localparam logic [4:0]  DITHER_PCT_MID     = 5'h0a;
    localparam logic [4:0]  DITHER_PCT_HIGH    = 5'h0f;

endpackage

// File: rtl/mcr_shift_decode.sv
/*
 * Mantissa/exponent decoder: forms mantissa shifted left by exponent and
 * holds it in a register. Assumes a synchronous active-high reset.
 */
`timescale 1ns/100ps

module mcr_shift_decode
(
    clock,
    sys_rst,
    mantissa,
    exponent,
    value_q
);
    input  wire logic                              clock;
    input  wire logic                              sys_rst;
    input  wire logic [mcr_pkg::MAN_W-1:0]         mantissa;
    input  wire logic [mcr_pkg::EXP_W-1:0]         exponent;
    output      logic [mcr_pkg::SCALED_W-1:0]      value_q;

    // =========================================================================
    // Scaled value
    // =========================================================================
    logic [mcr_pkg::SCALED_W-1:0] value_d;

    // Widen then shift; largest result fits exactly
    always_comb
    begin
        value_d = {{(mcr_pkg::SCALED_W-mcr_pkg::MAN_W){1'b0}}, mantissa} << exponent;
    end

    // Hold the result
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            value_q <= '0;
        else
            value_q <= value_d;
    end

endmodule

// File: rtl/mcr_tach_gen.sv
/*
 * Tachometer divider: toggles the tach output after every n+1 electrical
 * half-cycle strobes, so the output runs at electrical speed / (n+1).
 * Assumes one strobe per electrical half-cycle, synchronous to clock.
 */
`timescale 1ns/100ps

module mcr_tach_gen
(
    clock,
    sys_rst,
    enable,
    half_cycle_pulse,
    divider,
    tach_output_q
);
    input  wire logic        clock;
    input  wire logic        sys_rst;
    input  wire logic        enable;
    input  wire logic        half_cycle_pulse;
    input  wire logic [3:0]  divider;
    output      logic        tach_output_q;

    // =========================================================================
    // Half-cycle counter and output toggle
    // =========================================================================
    logic [3:0] count_q;

    // Count strobes; wrap and toggle at the divider value
    always_ff @(posedge clock)
    begin
        if (sys_rst || !enable)
        begin
            count_q       <= 4'h0;
            tach_output_q <= 1'b0;   // Held low while suppressed
        end
        else if (half_cycle_pulse)
        begin
            if (count_q >= divider)
            begin
                count_q       <= 4'h0;
                tach_output_q <= ~tach_output_q;
            end
            else
                count_q <= count_q + 4'h1;
        end
    end

endmodule

// File: rtl/mcr_top.sv
/*
 * Motor configuration register bank: two 16-bit configuration registers
 * reached over the device's internal register port (behind the serial
 * register interface), plus the decoded settings they steer: dither level,
 * tachometer gating and division, resistance, BACK_EMF constant and the
 * commutation advance time.
 * Assumes all inputs synchronous to clock; the motor control core supplies
 * loop phase levels, half-cycle strobes, supply and back-EMF levels.
 */

// Functional notes
// - Dither code selects off, 5, 10, 15 percent
// - Tach select 00: output open and closed loop
// - Tach select 01: closed loop after 280 ms
// - Tach select 10: closed loop, first open loop
// - Tach frequency is electrical speed over n+1
// - Resistance is mantissa shifted by exponent
// - BACK_EMF constant is mantissa shifted by exponent
// - Advance mode 0: fixed advance time
// - Advance mode 1: scale by supply minus BACK_EMF
// - Advance time is mantissa shifted by exponent
// - Both registers reset to zero

`timescale 1ns/100ps

module mcr_top
#(
    parameter int unsigned TACH_DELAY_CYCLES = mcr_pkg::TACH_DELAY_CYCLES
)
(
    clock,
    sys_rst,
    reg_wr,
    reg_rd,
    reg_addr,
    reg_wdata,
    reg_rdata_q,
    reg_rvalid_q,
    closed_loop,
    first_open_loop,
    half_cycle_pulse,
    supply_level,
    back_emf_level,
    tach_output_q,
    dither_level_select_q,
    dither_pct_q,
    cycle_adjust_half_q,
    phase_res_q,
    back_emf_const_q,
    advance_mode_select_q,
    advance_time_q
);
    input  wire logic                                clock;
    input  wire logic                                sys_rst;
    input  wire logic                                reg_wr;
    input  wire logic                                reg_rd;
    input  wire logic [mcr_pkg::ADDR_W-1:0]          reg_addr;
    input  wire logic [mcr_pkg::DATA_W-1:0]          reg_wdata;
    output      logic [mcr_pkg::DATA_W-1:0]          reg_rdata_q;
    output      logic                                reg_rvalid_q;
    input  wire logic                                closed_loop;
    input  wire logic                                first_open_loop;
    input  wire logic                                half_cycle_pulse;
    input  wire logic [mcr_pkg::LEVEL_W-1:0]         supply_level;
    input  wire logic [mcr_pkg::LEVEL_W-1:0]         back_emf_level;
    output      logic                                tach_output_q;
    output      logic [1:0]                          dither_level_select_q;
    output      logic [4:0]                          dither_pct_q;
    output      logic                                cycle_adjust_half_q;
    output      logic [mcr_pkg::SCALED_W-1:0]        phase_res_q;
    output      logic [mcr_pkg::SCALED_W-1:0]        back_emf_const_q;
    output      logic                                advance_mode_select_q;
    output      logic [mcr_pkg::SCALED_W-1:0]        advance_time_q;

    // =========================================================================
    // Register storage
    // =========================================================================
    logic [mcr_pkg::DATA_W-1:0] drive_config_a_q;
    logic [mcr_pkg::DATA_W-1:0] drive_config_b_q;

    // First configuration register, all bits writable
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            drive_config_a_q <= mcr_pkg::RESET_CONFIG_A;
        else if (reg_wr && reg_addr == mcr_pkg::ADDR_CONFIG_A)
            drive_config_a_q <= reg_wdata;
    end

    // Second configuration register, reserved top bit forced low
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            drive_config_b_q <= mcr_pkg::RESET_CONFIG_B;
        else if (reg_wr && reg_addr == mcr_pkg::ADDR_CONFIG_B)
            drive_config_b_q <= reg_wdata & mcr_pkg::WMASK_CONFIG_B;
    end

    // =========================================================================
    // Read port
    // =========================================================================
    logic [mcr_pkg::DATA_W-1:0] rdata_d;

    // Address decode; unmapped addresses read zero
    always_comb
    begin
        case (reg_addr)
            mcr_pkg::ADDR_CONFIG_A: rdata_d = drive_config_a_q;
            mcr_pkg::ADDR_CONFIG_B: rdata_d = drive_config_b_q & mcr_pkg::WMASK_CONFIG_B;
            default:                rdata_d = '0;
        endcase
    end

    // Read data one cycle after the strobe, held until the next read
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            reg_rdata_q  <= '0;
            reg_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd)
                reg_rdata_q <= rdata_d;
        end
    end

    // =========================================================================
    // Field extraction
    // =========================================================================
    logic [1:0] dither_level_select;
    logic [1:0] tach_open_loop_select;
    logic [3:0] tach_pole_divider;
    logic       cycle_adjust_select;
    logic       advance_mode_select;

    // Named views of the stored fields
    assign dither_level_select   = drive_config_a_q[mcr_pkg::DITHER_MSB:mcr_pkg::DITHER_LSB];
    assign tach_open_loop_select = drive_config_a_q[mcr_pkg::TACH_OL_MSB:mcr_pkg::TACH_OL_LSB];
    assign tach_pole_divider     = drive_config_a_q[mcr_pkg::TACH_DIV_MSB:mcr_pkg::TACH_DIV_LSB];
    assign cycle_adjust_select   = drive_config_a_q[mcr_pkg::CYCLE_ADJ_BIT];
    assign advance_mode_select   = drive_config_b_q[mcr_pkg::ADV_MODE_BIT];

    // =========================================================================
    // Dither and cycle adjust outputs
    // =========================================================================
    logic [4:0] dither_pct_d;

    // Dither code to percent span
    always_comb
    begin
        case (dither_level_select)
            2'h0:    dither_pct_d = mcr_pkg::DITHER_PCT_OFF;
            2'h1:    dither_pct_d = mcr_pkg::DITHER_PCT_LOW;
            2'h2:    dither_pct_d = mcr_pkg::DITHER_PCT_MID;
            2'h3:    dither_pct_d = mcr_pkg::DITHER_PCT_HIGH;
            default: dither_pct_d = mcr_pkg::DITHER_PCT_OFF;
        endcase
    end

    // Registered copies of the plain settings
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            dither_level_select_q <= 2'h0;
            dither_pct_q          <= mcr_pkg::DITHER_PCT_OFF;
            cycle_adjust_half_q   <= 1'b0;
            advance_mode_select_q <= 1'b0;
        end
        else
        begin
            dither_level_select_q <= dither_level_select;
            dither_pct_q          <= dither_pct_d;
            cycle_adjust_half_q   <= cycle_adjust_select;
            advance_mode_select_q <= advance_mode_select;
        end
    end

    // =========================================================================
    // Tachometer gating
    // =========================================================================
    logic [mcr_pkg::DELAY_CNT_W-1:0] delay_cnt_q;
    logic                            delay_done_q;
    logic                            tach_enable;

    // Time spent in closed loop, restarted on each entry
    // Stops at the limit, so it never wraps
    always_ff @(posedge clock)
    begin
        if (sys_rst || !closed_loop)
        begin
            delay_cnt_q  <= '0;
            delay_done_q <= 1'b0;
        end
        else if (delay_cnt_q >= TACH_DELAY_CYCLES[mcr_pkg::DELAY_CNT_W-1:0] - 1'b1)
            delay_done_q <= 1'b1;
        else
            delay_cnt_q <= delay_cnt_q + 1'b1;
    end

    // Which loop phases let the tach output run
    always_comb
    begin
        case (tach_open_loop_select)
            mcr_pkg::TACH_OL_BOTH:    tach_enable = 1'b1;
            mcr_pkg::TACH_OL_DELAYED: tach_enable = closed_loop && delay_done_q;
            mcr_pkg::TACH_OL_FIRST:   tach_enable = closed_loop || first_open_loop;
            default:                  tach_enable = 1'b1;   // Reserved code acts as 00
        endcase
    end

    // Divide electrical speed by pole divider plus one
    mcr_tach_gen u_tach_gen
    (
        .clock            (clock),
        .sys_rst          (sys_rst),
        .enable           (tach_enable),
        .half_cycle_pulse (half_cycle_pulse),
        .divider          (tach_pole_divider),
        .tach_output_q    (tach_output_q)
    );

    // =========================================================================
    // Mantissa and exponent decoders
    // =========================================================================
    logic [mcr_pkg::SCALED_W-1:0] adv_setting_q;

    // Phase resistance
    mcr_shift_decode u_res_decode
    (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .mantissa (drive_config_a_q[mcr_pkg::RES_MAN_MSB:mcr_pkg::RES_MAN_LSB]),
        .exponent (drive_config_a_q[mcr_pkg::RES_EXP_MSB:mcr_pkg::RES_EXP_LSB]),
        .value_q  (phase_res_q)
    );

    // BACK_EMF constant
    mcr_shift_decode u_back_emf_decode
    (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .mantissa (drive_config_b_q[mcr_pkg::BACK_EMF_MAN_MSB:mcr_pkg::BACK_EMF_MAN_LSB]),
        .exponent (drive_config_b_q[mcr_pkg::BACK_EMF_EXP_MSB:mcr_pkg::BACK_EMF_EXP_LSB]),
        .value_q  (back_emf_const_q)
    );

    // Programmed advance setting
    mcr_shift_decode u_adv_decode
    (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .mantissa (drive_config_b_q[mcr_pkg::ADV_MAN_MSB:mcr_pkg::ADV_MAN_LSB]),
        .exponent (drive_config_b_q[mcr_pkg::ADV_EXP_MSB:mcr_pkg::ADV_EXP_LSB]),
        .value_q  (adv_setting_q)
    );

    // =========================================================================
    // Commutation advance time
    // =========================================================================
    localparam int unsigned PROD_W = mcr_pkg::SCALED_W + mcr_pkg::LEVEL_W;

    logic [mcr_pkg::LEVEL_W-1:0]  headroom;
    logic [PROD_W-1:0]            adv_product;
    logic [PROD_W-1:0]            adv_quotient;
    logic [mcr_pkg::SCALED_W-1:0] advance_time_d;

    // Supply minus back EMF, floored at zero
    assign headroom    = (back_emf_level >= supply_level) ? '0 : supply_level - back_emf_level;
    assign adv_product = {{mcr_pkg::LEVEL_W{1'b0}}, adv_setting_q} * {{mcr_pkg::SCALED_W{1'b0}}, headroom};

    // Scale by headroom over supply; never exceeds the setting
    always_comb
    begin
        if (supply_level == '0)
            adv_quotient = '0;
        else
            adv_quotient = adv_product / {{mcr_pkg::SCALED_W{1'b0}}, supply_level};
        if (advance_mode_select)
            advance_time_d = adv_quotient[mcr_pkg::SCALED_W-1:0];
        else
            advance_time_d = adv_setting_q;
    end

    // Registered advance time
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            advance_time_q <= '0;
        else
            advance_time_q <= advance_time_d;
    end

endmodule

// File: verif/mcr_top_assertions.sv
/* Checker for the register bank, bound to mcr_top.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps

module mcr_top_assertions
(
    input wire logic                         clock,
    input wire logic                         sys_rst,
    input wire logic                         reg_wr,
    input wire logic                         reg_rd,
    input wire logic [mcr_pkg::ADDR_W-1:0]   reg_addr,
    input wire logic [mcr_pkg::DATA_W-1:0]   reg_rdata_q,
    input wire logic                         reg_rvalid_q,
    input wire logic                         half_cycle_pulse,
    input wire logic [mcr_pkg::LEVEL_W-1:0]  supply_level,
    input wire logic [mcr_pkg::LEVEL_W-1:0]  back_emf_level,
    input wire logic                         tach_output_q,
    input wire logic [1:0]                   dither_level_select_q,
    input wire logic [4:0]                   dither_pct_q,
    input wire logic                         cycle_adjust_half_q,
    input wire logic [mcr_pkg::SCALED_W-1:0] phase_res_q,
    input wire logic [mcr_pkg::SCALED_W-1:0] back_emf_const_q,
    input wire logic                         advance_mode_select_q,
    input wire logic [mcr_pkg::SCALED_W-1:0] advance_time_q
);
    // ==========
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_reset_zero;
        disable iff (1'h0) sys_rst |=> {reg_rdata_q, reg_rvalid_q, tach_output_q, dither_pct_q, phase_res_q,
            back_emf_const_q, advance_time_q, advance_mode_select_q, cycle_adjust_half_q} == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("output not cleared");

    property p_rsvd_zero;
        reg_rd && reg_addr == mcr_pkg::ADDR_CONFIG_B |=> !reg_rdata_q[15];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

    property p_dither_pct;
        dither_pct_q == 5'(dither_level_select_q * 5);
    endproperty
    a_dither_pct: assert property (p_dither_pct) else $error("dither span wrong");

    property p_tach_rise;
        $rose(tach_output_q) |-> $past(half_cycle_pulse);
    endproperty
    a_tach_rise: assert property (p_tach_rise) else $error("tach rose without strobe");

    property p_cycle_adj;
        $changed(cycle_adjust_half_q) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == mcr_pkg::ADDR_CONFIG_A;
    endproperty
    a_cycle_adj: assert property (p_cycle_adj) else $error("cycle adjust not from write");

    property p_res_src;
        $changed(phase_res_q) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == mcr_pkg::ADDR_CONFIG_A;
    endproperty
    a_res_src: assert property (p_res_src) else $error("resistance not from write");

    property p_back_emf_src;
        $changed(back_emf_const_q) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == mcr_pkg::ADDR_CONFIG_B;
    endproperty
    a_back_emf_src: assert property (p_back_emf_src) else $error("back_emf not from write");

    property p_adv_fixed;
        !advance_mode_select_q && !$past(advance_mode_select_q) && $changed(advance_time_q)
            |-> $past(reg_wr, 3) && $past(reg_addr, 3) == mcr_pkg::ADDR_CONFIG_B;
    endproperty
    a_adv_fixed: assert property (p_adv_fixed) else $error("fixed advance time varied");

    property p_adv_zero;
        advance_mode_select_q && !$past(reg_wr) && back_emf_level >= supply_level |=> advance_time_q == '0;
    endproperty
    a_adv_zero: assert property (p_adv_zero) else $error("advance not zero at full back_emf");
endmodule

bind mcr_top mcr_top_assertions u_mcr_chk
(
    .clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .half_cycle_pulse(half_cycle_pulse),
    .supply_level(supply_level), .back_emf_level(back_emf_level), .tach_output_q(tach_output_q),
    .dither_level_select_q(dither_level_select_q), .dither_pct_q(dither_pct_q),
    .cycle_adjust_half_q(cycle_adjust_half_q), .phase_res_q(phase_res_q), .back_emf_const_q(back_emf_const_q),
    .advance_mode_select_q(advance_mode_select_q), .advance_time_q(advance_time_q)
);

// File: verif/mcr_host_model.sv
/* Host model: register write and read tasks, code packer.
   Assumes calls follow reset release. */
`timescale 1ns/100ps

module mcr_host_model
(
    input  wire logic        clock,
    input  wire logic [15:0] reg_rdata_q,
    input  wire logic        reg_rvalid_q,
    output      logic        reg_wr,
    output      logic        reg_rd,
    output      logic [7:0]  reg_addr,
    output      logic [15:0] reg_wdata
);
    // ==========
    // Idle levels
    initial
    begin
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end

    // One-cycle write, then scramble lines
    task automatic write_reg(input logic [7:0] a, input logic [15:0] dat);
        @(negedge clock);
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = dat;
        @(negedge clock);
        reg_wr = 1'h0;
        reg_addr = ~a;
        reg_wdata = ~dat;
    endtask

    // One-cycle read, answer one cycle on
    task automatic read_reg(input logic [7:0] a, output logic [15:0] dat);
        @(negedge clock);
        reg_rd = 1'h1;
        reg_addr = a;
        @(negedge clock);
        reg_rd = 1'h0;
        reg_addr = ~a;
        dat = (reg_rvalid_q === 1'h1) ? reg_rdata_q : 16'hxxxx;
    endtask

    // Pack a code as exponent, mantissa
    function automatic logic [6:0] enc_code(input logic [10:0] code);
        logic [2:0] e;
        e = 3'h0;
        for (int i = 4; i < 11; i++)
            if (code[i])
                e = 3'(i - 3);
        return {e, 4'(code >> e)};
    endfunction
endmodule

// File: verif/tb_top.sv
/* Bench for the register bank.
   Assumes the host model drives the port at falling edges. */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
    $display("FAIL %s exp %h got %h", nm, ex, got); end end

module tb_top;
    logic        clock, sys_rst, reg_wr, reg_rd, reg_rvalid_q, closed_loop, first_open_loop;
    logic        half_cycle_pulse, tach_output_q, cycle_adjust_half_q, advance_mode_select_q;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata_q, d;
    logic [11:0] supply_level, back_emf_level;
    logic [1:0]  dither_level_select_q;
    logic [4:0]  dither_pct_q;
    logic [10:0] phase_res_q, back_emf_const_q, advance_time_q, code;
    logic [6:0]  res;
    int          fails, n_checks, cycles, i;

    // ==========
    // Design and host
    mcr_top #(.TACH_DELAY_CYCLES(20)) uut
    (
        .clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .closed_loop(closed_loop), .first_open_loop(first_open_loop), .half_cycle_pulse(half_cycle_pulse),
        .supply_level(supply_level), .back_emf_level(back_emf_level), .tach_output_q(tach_output_q),
        .dither_level_select_q(dither_level_select_q), .dither_pct_q(dither_pct_q),
        .cycle_adjust_half_q(cycle_adjust_half_q), .phase_res_q(phase_res_q), .back_emf_const_q(back_emf_const_q),
        .advance_mode_select_q(advance_mode_select_q), .advance_time_q(advance_time_q)
    );
    mcr_host_model host
    (
        .clock(clock), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
    );

    // Clock and hang guard
    always #5 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            end_sim();
        end
    end

    // Verdict
    task automatic end_sim;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Read and compare
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] ex);
        host.read_reg(a, d);
        `CHK(nm, ex, d)
    endtask

    // Half-cycle strobes, then settle
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(negedge clock);
            half_cycle_pulse = 1'h1;
            @(negedge clock);
            half_cycle_pulse = 1'h0;
        end
        repeat (2) @(negedge clock);
    endtask

    // Main sequence
    initial
    begin
        clock = 1'h0;
        sys_rst = 1'h1;
        closed_loop = 1'h0;
        first_open_loop = 1'h0;
        half_cycle_pulse = 1'h0;
        supply_level = 12'h3e8;
        back_emf_level = 12'h0fa;
        repeat (8) @(negedge clock);
        sys_rst = 1'h0;
        rd_chk("cfg_a_rst", mcr_pkg::ADDR_CONFIG_A, 16'h0000);
        rd_chk("cfg_b_rst", mcr_pkg::ADDR_CONFIG_B, 16'h0000);
        rd_chk("unmapped", 8'h92, 16'h0000);
        for (i = 0; i < 4; i++)
        begin
            host.write_reg(mcr_pkg::ADDR_CONFIG_A, {i[1:0], 6'h00, i[0], 7'h00});
            repeat (3) @(negedge clock);
            `CHK("dither_sel", i[1:0], dither_level_select_q)
            `CHK("dither_pct", 5'(i * 5), dither_pct_q)
            `CHK("cycle_adj", i[0], cycle_adjust_half_q)
            rd_chk("cfg_a_rb", mcr_pkg::ADDR_CONFIG_A, {i[1:0], 6'h00, i[0], 7'h00});
        end
        for (i = 0; i < 8; i++)
        begin
            code = 11'h00b << i;
            res = host.enc_code(code);
            host.write_reg(mcr_pkg::ADDR_CONFIG_A, {9'h000, res});
            host.write_reg(mcr_pkg::ADDR_CONFIG_B, {1'h0, res, 1'h0, host.enc_code(11'h005 << (7 - i))});
            repeat (3) @(negedge clock);
            `CHK("phase_res", code, phase_res_q)
            `CHK("back_emf_const", code, back_emf_const_q)
            `CHK("adv_time", 11'h005 << (7 - i), advance_time_q)
        end
        host.write_reg(mcr_pkg::ADDR_CONFIG_B, 16'h7fff);
        rd_chk("cfg_b_rsvd", mcr_pkg::ADDR_CONFIG_B, 16'h7fff);
        repeat (3) @(negedge clock);
        `CHK("adv_mode", 1'h1, advance_mode_select_q)
        `CHK("adv_scaled", 11'h5a0, advance_time_q)
        back_emf_level = 12'h3e8;
        repeat (3) @(negedge clock);
        `CHK("adv_zero", 11'h000, advance_time_q)
        host.write_reg(mcr_pkg::ADDR_CONFIG_A, 16'h0200);
        pulses(2);
        `CHK("tach_early", 1'h0, tach_output_q)
        pulses(1);
        `CHK("tach_rise", 1'h1, tach_output_q)
        pulses(3);
        `CHK("tach_fall", 1'h0, tach_output_q)
        host.write_reg(mcr_pkg::ADDR_CONFIG_A, 16'h1200);
        pulses(3);
        `CHK("tach_open", 1'h0, tach_output_q)
        closed_loop = 1'h1;
        pulses(3);
        `CHK("tach_delay", 1'h0, tach_output_q)
        repeat (30) @(negedge clock);
        pulses(3);
        `CHK("tach_closed", 1'h1, tach_output_q)
        host.write_reg(mcr_pkg::ADDR_CONFIG_A, 16'h2200);
        closed_loop = 1'h0;
        pulses(3);
        `CHK("tach_later_ol", 1'h0, tach_output_q)
        first_open_loop = 1'h1;
        pulses(3);
        `CHK("tach_first_ol", 1'h1, tach_output_q)
        end_sim();
    end
endmodule
